// ### src/waveform_parallel_port.sv
// Waveform parallel output port: streams the record memory to a receiver.
// Assumes a record memory with one cycle read latency and a digitizer
// that reports trigger and completion as one-cycle pulses.
// ============================================================
// Notes on behaviour
// [R1] Armed or taking acquisition ignores acquire, retransmit.
// [R2] Handshake mode sends only on receiver request.
// [R3] Synchronous mode strobes each word, no handshake.
// [R4] Continuous dump repeats record until new acquisition.
// [R5] Dump setting resets to off.
// [R6] Enabling dump forces scope off, mode handshake.
// [R7] Byte format sends one byte per cycle.
// [R8] Word format sends sixteen bits; default format.
// [R9] Bytes on low lines, high byte first.
// [R10] Mode accepts only 1 or 2; default 1.
// [R11] Scope off keeps port idle unless dump is on; default off.
// [R12] All scope sends fixed 262144 bytes.
// [R13] Valid scope sends only valid data.
// [R14] Acquire low acquires; retransmit low restarts record. The code acts on both pins only while dump is on.
// [R15] Toggle output flips at each transmission start.
// [R16] Digitizer active high while acquiring.
// [R17] Data latched on strobe rising edge.
// [R18] Synchronous data stable whole word period.
`include "wpp_map.svh"
module waveform_parallel_port
    import wpp_pkg::*;
#(
    parameter int HALF_CYC = `WPP_HALF_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_dump_in,
    input  wire logic [1:0]  cfg_scope_in,
    input  wire logic [1:0]  cfg_mode_in,
    input  wire logic        cfg_byte_fmt_in,
    output logic             dump_out,
    output logic [1:0]       scope_out,
    output logic [1:0]       mode_out,
    output logic             byte_fmt_out,
    output logic [18:0]      length_bytes_out,
    input  wire logic        acq_start_in,
    input  wire logic        send_start_in,
    input  wire logic        trigger_in,
    input  wire logic        acq_done_in,
    input  wire logic [17:0] valid_words_in,
    output logic [16:0]      mem_addr_out,
    input  wire logic [15:0] mem_data_in,
    input  wire logic        acquire_request_in,
    input  wire logic        retransmit_request_in,
    input  wire logic        receiver_request_in,
    output logic [15:0]      port_data_out,
    output logic             data_latch_pulse_out,
    output logic             digitizer_active_out,
    output logic             transfer_toggle_out,
    output logic             port_active_out
);
    // ============================================================
    // Pin synchronisers
    logic [2:0] pin_raw;
    logic [2:0] pin_s;
    logic [2:0] pin_prev_ff;
    assign pin_raw = {receiver_request_in, retransmit_request_in, acquire_request_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            pin_sync u_sync (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .pin_in   (pin_raw[gi]),
                .sync_out (pin_s[gi])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pin_prev_ff <= 3'h7;
        else
            pin_prev_ff <= pin_s;
    end

    wire acq_pin_fall  = pin_prev_ff[0] & ~pin_s[0];
    wire retx_pin_fall = pin_prev_ff[1] & ~pin_s[1];
    wire req_high      = pin_s[2];

    // ============================================================
    // Settings
    logic       dump_ff;
    logic [1:0] scope_ff;
    logic [1:0] mode_ff;
    logic       byte_fmt_ff;
    wire        mode_legal = (cfg_mode_in == `WPP_MODE_HS) || (cfg_mode_in == `WPP_MODE_SYNC);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dump_ff     <= `WPP_RST_DUMP; // [R5]
            scope_ff    <= `WPP_RST_SCOPE; // [R11]
            mode_ff     <= `WPP_RST_MODE; // [R10]
            byte_fmt_ff <= `WPP_RST_BYTE_FMT; // [R8]
        end
        else if (cfg_wr_in)
        begin
            dump_ff     <= cfg_dump_in;
            byte_fmt_ff <= cfg_byte_fmt_in;
            if (cfg_dump_in)
            begin
                scope_ff <= `WPP_SCOPE_OFF; // [R6]
                mode_ff  <= `WPP_MODE_HS; // [R6]
            end
            else
            begin
                scope_ff <= (cfg_scope_in == 2'h3) ? scope_ff : cfg_scope_in;
                if (mode_legal)
                    mode_ff <= cfg_mode_in; // [R10]
            end
        end
    end

    assign dump_out     = dump_ff;
    assign scope_out    = scope_ff;
    assign mode_out     = mode_ff;
    assign byte_fmt_out = byte_fmt_ff;

    // Dump streams the valid record even though its scope reads off.
    wire        active    = dump_ff | (scope_ff != `WPP_SCOPE_OFF); // [R11]
    wire        sync_mode = (mode_ff == `WPP_MODE_SYNC);
    wire [18:0] valid_bytes = {valid_words_in, 1'b0};
    wire [18:0] rec_bytes = (scope_ff == `WPP_SCOPE_ALL) ? `WPP_ALL_BYTES // [R12]
                                                          : valid_bytes; // [R13]
    assign length_bytes_out = rec_bytes;
    assign port_active_out  = active;

    // ============================================================
    // Acquisition control
    acq_state_e acq_ff;
    acq_state_e nxt_acq;
    wire acq_idle = (acq_ff == ACQ_IDLE);
    // Requests while armed or taking are dropped, not queued.
    wire acq_go   = acq_idle & (acq_start_in | (dump_ff & acq_pin_fall)); // [R1] [R14]
    wire acq_done_evt = (acq_ff == ACQ_TAKING) & acq_done_in;

    always_comb
    begin
        nxt_acq = acq_ff;
        case (acq_ff)
            ACQ_IDLE:   if (acq_go) nxt_acq = ACQ_ARMED;
            ACQ_ARMED:  if (trigger_in) nxt_acq = ACQ_TAKING;
            ACQ_TAKING: if (acq_done_in) nxt_acq = ACQ_IDLE;
            default:    nxt_acq = ACQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            acq_ff <= ACQ_IDLE;
        else
            acq_ff <= nxt_acq;
    end

    assign digitizer_active_out = ~acq_idle; // [R16]

    // ============================================================
    // Transfer engine
    xfer_state_e xf_ff;
    xfer_state_e nxt_xf;
    logic [18:0] left_ff;
    logic [16:0] addr_ff;
    logic        phase_ff;
    logic [15:0] word_ff;
    logic [15:0] data_ff;
    logic        strobe_ff;
    logic        toggle_ff;
    logic [7:0]  cnt_ff;

    wire retx_ok = dump_ff & acq_idle & retx_pin_fall; // [R1] [R14]
    wire send_ok = active & acq_idle & send_start_in;
    wire start   = (active & acq_done_evt) | retx_ok | send_ok;
    wire [18:0] step = byte_fmt_ff ? 19'h1 : 19'h2;
    wire last_unit  = (left_ff <= step);
    wire cnt_zero   = (cnt_ff == 8'h0);
    wire unit_done  = sync_mode ? (xf_ff == XF_STROBE) & cnt_zero
                                : (xf_ff == XF_RELEASE) & ~req_high; // [R2]
    wire loop_again = unit_done & last_unit & dump_ff; // [R4]
    wire begin_rec  = (start | loop_again) & (rec_bytes != 19'h0);
    wire next_word  = ~byte_fmt_ff | phase_ff;
    // Synchronous mode loads the lines while the word register is still filling,
    // and the second byte loads while the phase bit is still flipping.
    wire [15:0] load_word  = (xf_ff == XF_FETCH) ? mem_data_in : word_ff;
    wire        load_phase = unit_done ? (byte_fmt_ff & ~phase_ff) : phase_ff;
    wire [15:0] out_val = ~byte_fmt_ff ? load_word // [R8]
                        : (load_phase ? {8'h00, load_word[7:0]} // [R9]
                                      : {8'h00, load_word[15:8]}); // [R7] [R9]

    always_comb
    begin
        nxt_xf = xf_ff;
        case (xf_ff)
            XF_IDLE:    nxt_xf = XF_IDLE;
            XF_ADDR:    nxt_xf = XF_FETCH;
            XF_FETCH:   nxt_xf = sync_mode ? XF_SETUP : XF_WAIT; // [R3]
            XF_WAIT:    if (req_high) nxt_xf = XF_SETUP; // [R2]
            XF_SETUP:   if (cnt_zero) nxt_xf = XF_STROBE;
            XF_STROBE:  if (cnt_zero) nxt_xf = sync_mode ? XF_IDLE : XF_RELEASE;
            XF_RELEASE: if (!req_high) nxt_xf = XF_IDLE;
            default:    nxt_xf = XF_IDLE;
        endcase
        if (unit_done && !last_unit)
            nxt_xf = next_word ? XF_ADDR : (sync_mode ? XF_SETUP : XF_WAIT);
        if (begin_rec)
            nxt_xf = XF_ADDR;
        if (acq_go || !active)
            nxt_xf = XF_IDLE;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            xf_ff <= XF_IDLE;
        else
            xf_ff <= nxt_xf;
    end

    // Counter reloads on entry to setup and strobe halves.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cnt_ff <= 8'h0;
        else if ((nxt_xf == XF_SETUP || nxt_xf == XF_STROBE) && nxt_xf != xf_ff)
            cnt_ff <= 8'(HALF_CYC - 1);
        else if (unit_done && nxt_xf == XF_SETUP)
            cnt_ff <= 8'(HALF_CYC - 1);
        else if (!cnt_zero)
            cnt_ff <= cnt_ff - 8'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            left_ff   <= 19'h0;
            addr_ff   <= 17'h0;
            phase_ff  <= 1'b0;
            word_ff   <= 16'h0;
            toggle_ff <= 1'b0;
        end
        else if (begin_rec && !acq_go)
        begin
            left_ff   <= rec_bytes;
            addr_ff   <= 17'h0; // [R14]
            phase_ff  <= 1'b0;
            toggle_ff <= ~toggle_ff; // [R15]
        end
        else
        begin
            if (xf_ff == XF_FETCH)
                word_ff <= mem_data_in;
            if (unit_done)
            begin
                left_ff  <= last_unit ? 19'h0 : left_ff - step;
                phase_ff <= byte_fmt_ff & ~phase_ff;
                if (next_word)
                    addr_ff <= addr_ff + 17'h1;
            end
        end
    end

    // Data loads at setup entry and holds through the strobe half.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            data_ff   <= 16'h0;
            strobe_ff <= 1'b0;
        end
        else
        begin
            if (nxt_xf == XF_SETUP && xf_ff != XF_SETUP)
                data_ff <= out_val; // [R18]
            else if (unit_done && nxt_xf == XF_SETUP)
                data_ff <= out_val;
            strobe_ff <= (nxt_xf == XF_STROBE); // [R17] [R3]
        end
    end

    assign mem_addr_out         = addr_ff;
    assign port_data_out        = data_ff;
    assign data_latch_pulse_out = strobe_ff;
    assign transfer_toggle_out  = toggle_ff;
endmodule

// ### src/wpp_map.svh
// Offsets-free constant map for the waveform parallel output port.
// Assumes a single 40 MHz system clock; included by bare name.
`ifndef WPP_MAP_SVH
`define WPP_MAP_SVH
// ============================================================
// Timing
`define WPP_CLK_MHZ        40
`define WPP_WORD_PERIOD_NS 500
`define WPP_WORD_CYC       (((`WPP_WORD_PERIOD_NS * `WPP_CLK_MHZ) + 999) / 1000)
`define WPP_HALF_CYC       (`WPP_WORD_CYC / 2)
// ============================================================
// Setting encodings and reset values
`define WPP_MODE_HS        2'h1
`define WPP_MODE_SYNC      2'h2
`define WPP_SCOPE_OFF      2'h0
`define WPP_SCOPE_ALL      2'h1
`define WPP_SCOPE_VALID    2'h2
`define WPP_RST_MODE       2'h1
`define WPP_RST_SCOPE      2'h0
`define WPP_RST_DUMP       1'b0
`define WPP_RST_BYTE_FMT   1'b0
// ============================================================
// Record size
`define WPP_ALL_BYTES      19'h40000
`endif

// ### src/wpp_pkg.sv
// Types shared by the waveform parallel output port.
// Assumes nothing of its surroundings.
package wpp_pkg;
    typedef enum logic [1:0] {
        ACQ_IDLE   = 2'h0,
        ACQ_ARMED  = 2'h1,
        ACQ_TAKING = 2'h3
    } acq_state_e;

    typedef enum logic [2:0] {
        XF_IDLE    = 3'h0,
        XF_ADDR    = 3'h1,
        XF_FETCH   = 3'h3,
        XF_WAIT    = 3'h2,
        XF_SETUP   = 3'h6,
        XF_STROBE  = 3'h7,
        XF_RELEASE = 3'h5
    } xfer_state_e;
endpackage

// ### src/pin_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain.
// Assumes the consumer reads only sync_out.
module pin_sync
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      sync_out
);
    logic meta_ff;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meta_ff  <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_ff  <= pin_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// ### test/wpp_props.sv
// Checker for the waveform parallel output port, bound to its ports.
// Assumes one clock domain with a synchronous active-low reset.
module wpp_props
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        cfg_wr_in,
    input wire logic        cfg_dump_in,
    input wire logic [1:0]  cfg_mode_in,
    input wire logic        acq_start_in,
    input wire logic        acq_done_in,
    input wire logic [17:0] valid_words_in,
    input wire logic        dump_out,
    input wire logic [1:0]  scope_out,
    input wire logic [1:0]  mode_out,
    input wire logic        byte_fmt_out,
    input wire logic [18:0] length_bytes_out,
    input wire logic [15:0] port_data_out,
    input wire logic        data_latch_pulse_out,
    input wire logic        digitizer_active_out,
    input wire logic        transfer_toggle_out,
    input wire logic        port_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    property p_dump;
        cfg_wr_in && cfg_dump_in |=> dump_out && scope_out == 2'h0 && mode_out == 2'h1;
    endproperty
    property p_mode;
        cfg_wr_in && !cfg_dump_in |=> mode_out ==
            ($past(cfg_mode_in) inside {2'h1, 2'h2} ? $past(cfg_mode_in) : $past(mode_out));
    endproperty
    property p_all;
        scope_out == 2'h1 |-> length_bytes_out == 19'h40000;
    endproperty
    property p_valid;
        scope_out == 2'h2 |-> length_bytes_out == {valid_words_in, 1'b0};
    endproperty
    property p_active;
        port_active_out == (dump_out || scope_out != 2'h0);
    endproperty
    property p_idle;
        !port_active_out [*2] |-> !data_latch_pulse_out;
    endproperty
    property p_byte;
        byte_fmt_out && data_latch_pulse_out |-> port_data_out[15:8] == 8'h00;
    endproperty
    property p_hold;
        data_latch_pulse_out |-> $stable(port_data_out);
    endproperty
    property p_acq;
        acq_start_in && !digitizer_active_out |=> digitizer_active_out;
    endproperty
    property p_quiet;
        digitizer_active_out && !acq_done_in && !$past(acq_done_in) |=>
            $stable(transfer_toggle_out) ##0 !data_latch_pulse_out;
    endproperty
    a_dump: assert property (p_dump) else $error("dump write left scope or mode");
    a_mode: assert property (p_mode) else $error("mode write wrong");
    a_all: assert property (p_all) else $error("full length wrong");
    a_valid: assert property (p_valid) else $error("valid length wrong");
    a_active: assert property (p_active) else $error("port active wrong");
    a_idle: assert property (p_idle) else $error("strobe while inactive");
    a_byte: assert property (p_byte) else $error("byte on high lines");
    a_hold: assert property (p_hold) else $error("data moved under strobe");
    a_acq: assert property (p_acq) else $error("acquisition not started");
    a_quiet: assert property (p_quiet) else $error("transfer while acquiring");
    c_sync: cover property (mode_out == 2'h2 && $rose(data_latch_pulse_out));
    c_byte: cover property (byte_fmt_out && $rose(data_latch_pulse_out));
    c_dump: cover property (dump_out && $changed(transfer_toggle_out));
endmodule

bind waveform_parallel_port wpp_props i_wpp_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr_in(cfg_wr_in), .cfg_dump_in(cfg_dump_in),
    .cfg_mode_in(cfg_mode_in), .acq_start_in(acq_start_in), .acq_done_in(acq_done_in),
    .valid_words_in(valid_words_in), .dump_out(dump_out), .scope_out(scope_out),
    .mode_out(mode_out), .byte_fmt_out(byte_fmt_out), .length_bytes_out(length_bytes_out),
    .port_data_out(port_data_out), .data_latch_pulse_out(data_latch_pulse_out),
    .digitizer_active_out(digitizer_active_out),
    .transfer_toggle_out(transfer_toggle_out), .port_active_out(port_active_out));

// ### test/rx_model.sv
// Receiver model: latches each unit on the strobe and requests by level.
// Assumes its own link clock; the bench reads the got queue.
module rx_model
(
    input  wire logic        link_clk,
    input  wire logic        rx_en,
    input  wire logic        data_latch_pulse_out,
    input  wire logic [15:0] port_data_out,
    output logic             receiver_request_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] got[$];
    int          n_got = 0;
    int          n_ack = 0;
    // ============================================================
    // Capture and request
    always @(posedge data_latch_pulse_out)
    begin
        got.push_back(port_data_out);
        n_got++;
    end
    // Request must fall after each unit, or the device stays in its release state and sends no more.
    always @(posedge link_clk)
    begin
        receiver_request_in <= rx_en && (n_got == n_ack);
        n_ack = n_got;
    end
endmodule

// ### test/tb.sv
// Self-checking bench for the waveform parallel output port.
// Assumes the rx_model receiver; memory and digitizer are modelled here.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, cfg_wr_in, cfg_dump_in, cfg_byte_fmt_in, acq_start_in;
    logic        send_start_in, trigger_in, acq_done_in, acquire_request_in;
    logic        retransmit_request_in, receiver_request_in, link_clk, rx_en, t;
    logic        dump_out, byte_fmt_out, data_latch_pulse_out, digitizer_active_out;
    logic        transfer_toggle_out, port_active_out;
    logic [1:0]  cfg_scope_in, cfg_mode_in, scope_out, mode_out;
    logic [17:0] valid_words_in;
    logic [18:0] length_bytes_out;
    logic [16:0] mem_addr_out;
    logic [15:0] mem_data_in, port_data_out;
    int          num_errors = 0, checked = 0, i, n;
    waveform_parallel_port #(.HALF_CYC(2)) i_waveform_parallel_port (
        .sys_clk               (sys_clk),
        .rst_n                 (rst_n),
        .cfg_wr_in             (cfg_wr_in),
        .cfg_dump_in           (cfg_dump_in),
        .cfg_scope_in          (cfg_scope_in),
        .cfg_mode_in           (cfg_mode_in),
        .cfg_byte_fmt_in       (cfg_byte_fmt_in),
        .dump_out              (dump_out),
        .scope_out             (scope_out),
        .mode_out              (mode_out),
        .byte_fmt_out          (byte_fmt_out),
        .length_bytes_out      (length_bytes_out),
        .acq_start_in          (acq_start_in),
        .send_start_in         (send_start_in),
        .trigger_in            (trigger_in),
        .acq_done_in           (acq_done_in),
        .valid_words_in        (valid_words_in),
        .mem_addr_out          (mem_addr_out),
        .mem_data_in           (mem_data_in),
        .acquire_request_in    (acquire_request_in),
        .retransmit_request_in (retransmit_request_in),
        .receiver_request_in   (receiver_request_in),
        .port_data_out         (port_data_out),
        .data_latch_pulse_out  (data_latch_pulse_out),
        .digitizer_active_out  (digitizer_active_out),
        .transfer_toggle_out   (transfer_toggle_out),
        .port_active_out       (port_active_out)
    );
    rx_model i_rx_model (.link_clk(link_clk), .rx_en(rx_en), .port_data_out(port_data_out),
        .data_latch_pulse_out(data_latch_pulse_out), .receiver_request_in(receiver_request_in));
    initial begin sys_clk = 0; forever #12.5 sys_clk = ~sys_clk; end
    initial begin link_clk = 0; #37; forever #100 link_clk = ~link_clk; end
    always @(posedge sys_clk) mem_data_in <= {mem_addr_out[7:0] ^ 8'hA5, mem_addr_out[7:0]};
    // ============================================================
    // Tasks
    task cyc(input int c); repeat (c) @(posedge sys_clk); endtask
    task chk(input logic [18:0] got, input logic [18:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task cfg(input logic d, input logic [1:0] s, input logic [1:0] m, input logic b);
        cfg_wr_in <= 1; cfg_dump_in <= d; cfg_scope_in <= s; cfg_mode_in <= m;
        cfg_byte_fmt_in <= b; cyc(1); cfg_wr_in <= 0; cyc(2);
    endtask
    task pulse_send(); send_start_in <= 1; cyc(1); send_start_in <= 0; cyc(1); endtask
    task digi();
        cyc(3); trigger_in <= 1; cyc(1); trigger_in <= 0;
        cyc(3); acq_done_in <= 1; cyc(1); acq_done_in <= 0; cyc(3);
    endtask
    task wait_units(input int u);
        for (int k = 0; k < 4000 && i_rx_model.got.size() < u; k++) cyc(1);
    endtask
    // Byte format halves each word, so the expected unit index is folded back here.
    function automatic logic [15:0] exp_unit(input int k, input logic b);
        logic [7:0] w;
        w = 8'(b ? k / 2 : k);
        if (!b) return {w ^ 8'hA5, w};
        return (k % 2 == 0) ? {8'h00, w ^ 8'hA5} : {8'h00, w};
    endfunction
    task chk_rec(input int u, input int per, input logic b);
        for (int k = 0; k < u; k++) chk(i_rx_model.got[k], exp_unit(k % per, b));
        i_rx_model.got.delete();
    endtask
    task complete_run();
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin cyc(60000); num_errors++; complete_run(); end
    // ============================================================
    // Scenarios
    initial
    begin
        void'($urandom(55520));
        {rst_n, cfg_wr_in, cfg_dump_in, cfg_byte_fmt_in, acq_start_in, send_start_in} = 0;
        {trigger_in, acq_done_in, rx_en, cfg_scope_in, cfg_mode_in, valid_words_in} = 0;
        {acquire_request_in, retransmit_request_in} = 2'b11;
        cyc(12);
        rst_n <= 1;
        cyc(1);
        chk(mode_out, 2'h1);
        chk(dump_out, 0);
        chk(scope_out, 2'h0);
        chk(byte_fmt_out, 0);
        cfg(0, 2'h3, 2'h3, 0);
        chk(mode_out, 2'h1);
        chk(scope_out, 2'h0);
        for (i = 0; i < 4; i++)
        begin
            n = 2 + $urandom % 3;
            valid_words_in <= 18'(n);
            cfg(0, 2'h2, i[0] ? 2'h2 : 2'h1, i[1]);
            chk(length_bytes_out, 19'(2 * n));
            rx_en <= 0;
            t = transfer_toggle_out;
            pulse_send();
            cyc(40);
            if (!i[0])
                chk(19'(i_rx_model.got.size()), 0);
            else if (!i[1])
                chk(19'(i_rx_model.got.size()), 19'(n));
            rx_en <= !i[0];
            wait_units(i[1] ? 2 * n : n);
            chk(transfer_toggle_out, !t);
            chk_rec(i[1] ? 2 * n : n, i[1] ? 2 * n : n, i[1]);
        end
        // The full-memory record is far too long to drain, so only its head is checked.
        cfg(0, 2'h1, 2'h1, 0);
        chk(length_bytes_out, 19'h40000);
        rx_en <= 1;
        pulse_send();
        wait_units(4);
        chk_rec(4, 4, 0);
        cfg(0, 2'h0, 2'h1, 0);
        i_rx_model.got.delete();
        cfg(1, 2'h2, 2'h2, 1);
        chk(scope_out, 2'h0);
        chk(mode_out, 2'h1);
        pulse_send();
        wait_units(4 * n);
        chk_rec(4 * n, 2 * n, 1);
        acquire_request_in <= 0;
        cyc(6);
        chk(digitizer_active_out, 1);
        t = transfer_toggle_out;
        retransmit_request_in <= 0;
        cyc(8);
        chk(transfer_toggle_out, t);
        {acquire_request_in, retransmit_request_in} <= 2'b11;
        i_rx_model.got.delete();
        digi();
        chk(digitizer_active_out, 0);
        chk(transfer_toggle_out, !t);
        // One unit into the next loop, so no loop restart falls inside the retransmit window.
        wait_units(2 * n + 1);
        chk_rec(2 * n + 1, 2 * n, 1);
        t = transfer_toggle_out;
        retransmit_request_in <= 0;
        cyc(6);
        chk(transfer_toggle_out, !t);
        retransmit_request_in <= 1;
        wait_units(2 * n);
        chk_rec(2 * n, 2 * n, 1);
        cfg(0, 2'h0, 2'h1, 0);
        chk(port_active_out, 0);
        i_rx_model.got.delete();
        pulse_send();
        cyc(40);
        chk(19'(i_rx_model.got.size()), 0);
        acq_start_in <= 1;
        cyc(1);
        acq_start_in <= 0;
        cyc(1);
        chk(digitizer_active_out, 1);
        digi();
        chk(digitizer_active_out, 0);
        complete_run();
    end
endmodule
